// >>> rtl/parallel_config_load_interface.sv
// Fast parallel load port: reconfiguration handshake, word capture, init sequencing, APB registers
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - 8-bit mode ratio: 1 without decompression, 2 with it.
// - 16-bit mode ratio: 1 plain, 2 security only, 4 with decompression.
// - 32-bit mode ratio: 1 plain, 4 security only, 8 with decompression.
// - User mode keeps request, status and done high; falling request restarts.
// - Status held low during the power-on delay.
// - Done flag low after power-up, before and during the load.
// - Load clock ignored once configuration completes; host keeps it defined.
// - Done rises only after every expected word is received.
// - Enabled init-done output driven low until initialization finishes.
// - Done and status pulled low within 600 ns of request falling.
// - Status low pulse lasts 268 to 1506 us unless extended.
// - Status released within 1506 us of request rising unless held externally.
// - Internal oscillator init reaches user mode 175 to 437 us after done.
// - User init clock enabled 4 load periods after done, then 17408 periods.
// - Ratio 1 only with decompression off, and in 16- and 32-bit modes with security off too.
module parallel_config_load_interface #(
    parameter int POR_CYC        = cfg_pkg::POR_CYC,
    parameter int STATUS_CYC     = cfg_pkg::STATUS_CYC,
    parameter int CD2UM_CYC      = cfg_pkg::CD2UM_CYC,
    parameter int USR_INIT_EDGES = cfg_pkg::USR_INIT_EDGES
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        load_clock,
    input  wire logic        user_init_clock,
    input  wire logic        reconfig_n,
    input  wire logic [31:0] data_pins,
    input  wire logic        status_n_in,
    output logic             status_n_out,
    output logic             status_n_oe_n,
    output logic             cfg_done,
    output logic             init_done_out,
    output logic             init_done_oe_n,
    output logic             user_mode,
    output logic      [31:0] cfg_word,
    output logic             cfg_word_valid
);
    typedef struct packed {
        cfg_pkg::cfg_state_t st;
        logic [31:0]         cnt;
        logic [31:0]         ucnt;
        logic [2:0]          phase;
        logic [31:0]         words;
        logic [1:0]          falls;
        logic [31:0]         word;
        logic                word_valid;
        logic [31:0]         ctrl;
        logic [31:0]         expect_n;
        logic [31:0]         prdata;
        logic                nst_low;
        logic                done;
        logic                init_low;
        logic                umode;
    } core_t;

    core_t      s_reg;
    core_t      s_next;
    logic [1:0] mode;
    logic [3:0] r;
    logic       apb_wr;
    logic [31:0] status_word;

    pin_if pins ();

    pin_sampler u_samp (
        .pclk            (pclk),
        .presetn         (presetn),
        .load_clock      (load_clock),
        .user_init_clock (user_init_clock),
        .reconfig_n      (reconfig_n),
        .status_n_in     (status_n_in),
        .data_pins       (data_pins),
        .pins            (pins)
    );

    // Ratio in force follows the programmed width and features
    assign mode   = s_reg.ctrl[cfg_pkg::CTRL_MODE_LSB +: 2];
    assign r      = cfg_pkg::ratio(mode, s_reg.ctrl[cfg_pkg::CTRL_DECOMP], s_reg.ctrl[cfg_pkg::CTRL_SEC]);
    assign apb_wr = psel & penable & pwrite;

    // Status word seen by software
    always_comb begin
        status_word = 32'h00000000;
        status_word[cfg_pkg::STAT_NST] = ~s_reg.nst_low;
        status_word[cfg_pkg::STAT_CD]  = s_reg.done;
        status_word[cfg_pkg::STAT_UM]  = s_reg.umode;
        status_word[cfg_pkg::STAT_ID]  = ~s_reg.init_low;
        status_word[cfg_pkg::STAT_ST_LSB +: 6] = s_reg.st;
        status_word[cfg_pkg::STAT_R_LSB +: 4]  = r;
    end

    // Register access, load sequencing and initialization
    always_comb begin
        s_next            = s_reg;
        s_next.word_valid = 1'b0;
        if (psel && !penable) begin
            case (paddr)
                cfg_pkg::ADDR_CTRL:   s_next.prdata = s_reg.ctrl;
                cfg_pkg::ADDR_WORDS:  s_next.prdata = s_reg.expect_n;
                cfg_pkg::ADDR_STATUS: s_next.prdata = status_word;
                cfg_pkg::ADDR_RECV:   s_next.prdata = s_reg.words;
                default:              s_next.prdata = 32'h00000000;
            endcase
        end
        if (apb_wr) begin
            case (paddr)
                cfg_pkg::ADDR_CTRL:  s_next.ctrl = pwdata & cfg_pkg::CTRL_MASK;
                cfg_pkg::ADDR_WORDS: s_next.expect_n = pwdata;
                default:             ;
            endcase
        end
        case (s_reg.st)
            cfg_pkg::ST_POR: begin
                // Status stays low through the power-on delay
                s_next.cnt = s_reg.cnt + 32'h1;
                if (s_reg.cnt >= 32'(POR_CYC - 1)) begin
                    s_next.st      = cfg_pkg::ST_LOAD;
                    s_next.nst_low = 1'b0;
                    s_next.cnt     = 32'h0;
                    s_next.phase   = 3'h0;
                end
            end
            cfg_pkg::ST_CLEAR: begin
                // Timer runs from the request's release; a longer request extends the pulse
                if (!pins.reconfig_n_s) begin
                    s_next.cnt = 32'h0;
                end else if (s_reg.cnt >= 32'(STATUS_CYC - 1)) begin
                    s_next.st      = cfg_pkg::ST_LOAD;
                    s_next.nst_low = 1'b0;
                    s_next.cnt     = 32'h0;
                    s_next.phase   = 3'h0;
                end else begin
                    s_next.cnt = s_reg.cnt + 32'h1;
                end
            end
            cfg_pkg::ST_LOAD: begin
                // A status line still held low externally delays the load
                if (pins.lck_rise && pins.status_n_s) begin
                    if (s_reg.phase == 3'h0) begin
                        s_next.word       = pins.data_s & cfg_pkg::width_mask(mode);
                        s_next.word_valid = 1'b1;
                        s_next.words      = s_reg.words + 32'h1;
                        if (s_reg.words + 32'h1 >= s_reg.expect_n) begin
                            s_next.st    = cfg_pkg::ST_DONE;
                            s_next.done  = 1'b1;
                            s_next.falls = 2'h0;
                        end
                    end
                    if ({1'b0, s_reg.phase} >= r - 4'h1) begin
                        s_next.phase = 3'h0;
                    end else begin
                        s_next.phase = s_reg.phase + 3'h1;
                    end
                end
            end
            cfg_pkg::ST_DONE: begin
                // Rising edges are ignored; only the trailing falling edges count
                if (pins.lck_fall) begin
                    s_next.falls = s_reg.falls + 2'h1;
                    if (s_reg.falls == 2'(cfg_pkg::INIT_FALLS - 1)) begin
                        s_next.st   = cfg_pkg::ST_INIT;
                        s_next.cnt  = 32'h0;
                        s_next.ucnt = 32'h0;
                    end
                end
            end
            cfg_pkg::ST_INIT: begin
                if (s_reg.ctrl[cfg_pkg::CTRL_USRCLK]) begin
                    // Wait for the user clock to be enabled, then count its edges
                    if (s_reg.cnt < 32'(cfg_pkg::CD2CU_CYC)) begin
                        s_next.cnt = s_reg.cnt + 32'h1;
                    end else if (pins.uck_rise) begin
                        s_next.ucnt = s_reg.ucnt + 32'h1;
                        if (s_reg.ucnt >= 32'(USR_INIT_EDGES - 1)) begin
                            s_next.st = cfg_pkg::ST_USER;
                        end
                    end
                end else begin
                    s_next.cnt = s_reg.cnt + 32'h1;
                    if (s_reg.cnt >= 32'(CD2UM_CYC - 1)) begin
                        s_next.st = cfg_pkg::ST_USER;
                    end
                end
            end
            cfg_pkg::ST_USER: begin
                s_next.init_low = 1'b0;
                s_next.umode    = 1'b1;
            end
            default: begin
                s_next.st = cfg_pkg::ST_POR;
            end
        endcase
        // A low request outside power-on and clear restarts configuration from any other state
        if (!pins.reconfig_n_s && s_reg.st != cfg_pkg::ST_POR && s_reg.st != cfg_pkg::ST_CLEAR) begin
            s_next.st       = cfg_pkg::ST_CLEAR;
            s_next.cnt      = 32'h0;
            s_next.nst_low  = 1'b1;
            s_next.done     = 1'b0;
            s_next.umode    = 1'b0;
            s_next.init_low = 1'b1;
            s_next.words    = 32'h0;
            s_next.phase    = 3'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg          <= '0;
            s_reg.st       <= cfg_pkg::ST_POR;
            s_reg.nst_low  <= 1'b1;
            s_reg.init_low <= 1'b1;
            s_reg.ctrl     <= cfg_pkg::CTRL_RST;
            s_reg.expect_n <= cfg_pkg::WORDS_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Pins and bus answer; open-drain enables are low while pulling low
    assign prdata         = s_reg.prdata;
    assign pready         = 1'b1;
    assign pslverr        = psel & penable & ~cfg_pkg::mapped(paddr);
    assign status_n_out   = 1'b0;
    assign status_n_oe_n  = ~s_reg.nst_low;
    assign cfg_done       = s_reg.done;
    assign init_done_out  = 1'b0;
    assign init_done_oe_n = ~(s_reg.ctrl[cfg_pkg::CTRL_INITEN] & s_reg.init_low);
    assign user_mode      = s_reg.umode;
    assign cfg_word       = s_reg.word;
    assign cfg_word_valid = s_reg.word_valid;

    localparam int CF2CD_BOUND = cfg_pkg::CF2CD_CYC;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Checks on the load handshake
    AST_POR_STATUS: assert property (s_reg.st == cfg_pkg::ST_POR |-> !status_n_oe_n && !cfg_done)
        else $error("status released during power-on delay");
    AST_CLEAR_FAST: assert property ($fell(pins.reconfig_n_s) && s_reg.st != cfg_pkg::ST_POR
        |-> ##[1:CF2CD_BOUND] (!cfg_done && !status_n_oe_n))
        else $error("done or status not pulled low after request");
    AST_DONE_FULL: assert property ($rose(cfg_done) |-> s_reg.words == s_reg.expect_n
        && s_reg.st == cfg_pkg::ST_DONE)
        else $error("done raised before all words arrived");
    AST_DONE_LOW: assert property (s_reg.st inside {cfg_pkg::ST_CLEAR, cfg_pkg::ST_LOAD} |-> !cfg_done)
        else $error("done high before load completed");
    AST_RATIO_X8: assert property (mode == cfg_pkg::MODE_X8
        |-> r == (s_reg.ctrl[cfg_pkg::CTRL_DECOMP] ? 4'h2 : 4'h1))
        else $error("wrong 8-bit ratio");
    AST_RATIO_X16: assert property (mode == cfg_pkg::MODE_X16 && !s_reg.ctrl[cfg_pkg::CTRL_DECOMP]
        |-> r == (s_reg.ctrl[cfg_pkg::CTRL_SEC] ? 4'h2 : 4'h1))
        else $error("wrong 16-bit ratio");
    AST_RATIO_X32: assert property (mode == cfg_pkg::MODE_X32 && s_reg.ctrl[cfg_pkg::CTRL_DECOMP]
        |-> r == 4'h8)
        else $error("wrong 32-bit ratio");
    AST_USER_HIGH: assert property (s_reg.st == cfg_pkg::ST_USER && pins.reconfig_n_s
        |-> ##1 (cfg_done && status_n_oe_n && user_mode))
        else $error("lines not high in user mode");
    AST_IGNORE_CLOCK: assert property (s_reg.st inside {cfg_pkg::ST_INIT, cfg_pkg::ST_USER} && pins.lck_rise
        && pins.reconfig_n_s |=> !cfg_word_valid && $stable(s_reg.words))
        else $error("load clock acted on after completion");
    AST_INIT_DONE_LOW: assert property (s_reg.ctrl[cfg_pkg::CTRL_INITEN] && s_reg.st inside
        {cfg_pkg::ST_LOAD, cfg_pkg::ST_DONE, cfg_pkg::ST_INIT} |-> !init_done_oe_n)
        else $error("init-done released before initialization finished");
    AST_STATUS_MIN: assert property (s_reg.st == cfg_pkg::ST_CLEAR && s_next.st == cfg_pkg::ST_LOAD
        |-> s_reg.cnt == 32'(STATUS_CYC - 1) && pins.reconfig_n_s)
        else $error("status pulse released at wrong time");
    AST_TWO_FALLS: assert property (s_reg.st == cfg_pkg::ST_DONE ##1 s_reg.st == cfg_pkg::ST_INIT
        |-> $past(pins.lck_fall) && $past(s_reg.falls) == 2'h1)
        else $error("init started without two falling edges");

    COV_WORD: cover property (cfg_word_valid);
    COV_DONE: cover property ($rose(cfg_done));
    COV_USER: cover property ($rose(user_mode));
    COV_RECONFIG: cover property (s_reg.st == cfg_pkg::ST_USER ##1 s_reg.st == cfg_pkg::ST_CLEAR);
endmodule : parallel_config_load_interface

// >>> rtl/cfg_pkg.sv
// Constants, state encoding and decode helpers shared by the parallel load block
package cfg_pkg;
    // Clock and timing figures
    localparam int CLK_MHZ            = 100;
    localparam int POR_MS             = 4;
    localparam int POR_CYC            = POR_MS * 1000 * CLK_MHZ;
    localparam int CF2CD_NS           = 600;
    localparam int CF2CD_CYC          = (CF2CD_NS * CLK_MHZ) / 1000;
    localparam int STATUS_MIN_US      = 268;
    localparam int STATUS_CYC         = STATUS_MIN_US * CLK_MHZ;
    localparam int STATUS_MAX_US      = 1506;
    localparam int CD2UM_MIN_US       = 175;
    localparam int CD2UM_CYC          = CD2UM_MIN_US * CLK_MHZ;
    localparam int CD2CU_PERIODS      = 4;
    localparam int LCK_MAX_PERIOD_NS  = 10;
    localparam int CD2CU_CYC          = (CD2CU_PERIODS * LCK_MAX_PERIOD_NS * CLK_MHZ + 999) / 1000;
    localparam int USR_INIT_EDGES     = 17408;
    localparam int INIT_FALLS         = 2;

    // Register byte offsets
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_WORDS  = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_RECV   = 12'h00C;

    // Control fields and reset values
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DECOMP   = 2;
    localparam int CTRL_SEC      = 3;
    localparam int CTRL_INITEN   = 4;
    localparam int CTRL_USRCLK   = 5;
    localparam logic [31:0] CTRL_MASK = 32'h0000003F;
    localparam logic [31:0] CTRL_RST  = 32'h00000002;
    localparam logic [31:0] WORDS_RST = 32'h00000100;

    // Status fields
    localparam int STAT_NST    = 0;
    localparam int STAT_CD     = 1;
    localparam int STAT_UM     = 2;
    localparam int STAT_ID     = 3;
    localparam int STAT_ST_LSB = 4;
    localparam int STAT_R_LSB  = 12;

    // Bus width modes
    localparam logic [1:0] MODE_X8  = 2'h0;
    localparam logic [1:0] MODE_X16 = 2'h1;
    localparam logic [1:0] MODE_X32 = 2'h2;

    typedef enum logic [5:0] {
        ST_POR   = 6'h01,
        ST_CLEAR = 6'h02,
        ST_LOAD  = 6'h04,
        ST_DONE  = 6'h08,
        ST_INIT  = 6'h10,
        ST_USER  = 6'h20
    } cfg_state_t;

    // Load clock cycles per data word for a mode and feature set
    function automatic logic [3:0] ratio(input logic [1:0] mode, input logic decomp, input logic sec);
        logic [3:0] r;
        r = 4'h1;
        case (mode)
            MODE_X8:  r = decomp ? 4'h2 : 4'h1;
            MODE_X16: r = decomp ? 4'h4 : (sec ? 4'h2 : 4'h1);
            default:  r = decomp ? 4'h8 : (sec ? 4'h4 : 4'h1);
        endcase
        return r;
    endfunction : ratio

    // Data lanes in use for a mode
    function automatic logic [31:0] width_mask(input logic [1:0] mode);
        logic [31:0] m;
        m = 32'hFFFFFFFF;
        case (mode)
            MODE_X8:  m = 32'h000000FF;
            MODE_X16: m = 32'h0000FFFF;
            default:  m = 32'hFFFFFFFF;
        endcase
        return m;
    endfunction : width_mask

    // Address decode shared by read and write paths
    function automatic logic mapped(input logic [11:0] a);
        return (a == ADDR_CTRL) || (a == ADDR_WORDS) || (a == ADDR_STATUS) || (a == ADDR_RECV);
    endfunction : mapped
endpackage : cfg_pkg

// >>> rtl/pin_if.sv
// Synchronised pin levels and edges passed from the sampler to the core
`timescale 1ns/1ps
interface pin_if;
    logic        lck_rise;
    logic        lck_fall;
    logic        uck_rise;
    logic        reconfig_n_s;
    logic        status_n_s;
    logic [31:0] data_s;

    modport samp (output lck_rise, lck_fall, uck_rise, reconfig_n_s, status_n_s, data_s);
    modport core (input  lck_rise, lck_fall, uck_rise, reconfig_n_s, status_n_s, data_s);
endinterface : pin_if

// >>> rtl/pin_sampler.sv
// Two-stage synchronisers and edge detection for the configuration pins
`timescale 1ns/1ps
module pin_sampler (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load_clock,
    input  wire logic        user_init_clock,
    input  wire logic        reconfig_n,
    input  wire logic        status_n_in,
    input  wire logic [31:0] data_pins,
    pin_if.samp              pins
);
    typedef struct packed {
        logic [2:0]  lck;
        logic [2:0]  uck;
        logic [1:0]  rcf;
        logic [1:0]  stn;
        logic [31:0] d1;
        logic [31:0] d2;
        logic [31:0] d3;
        logic        rise;
        logic        fall;
        logic        urise;
    } samp_t;

    samp_t s_reg;
    samp_t s_next;

    // Shift chains; the first stage of each is read only by the second
    always_comb begin
        s_next       = s_reg;
        s_next.lck   = {s_reg.lck[1:0], load_clock};
        s_next.uck   = {s_reg.uck[1:0], user_init_clock};
        s_next.rcf   = {s_reg.rcf[0], reconfig_n};
        s_next.stn   = {s_reg.stn[0], status_n_in};
        s_next.d1    = data_pins;
        s_next.d2    = s_reg.d1;
        s_next.d3    = s_reg.d2;
        s_next.rise  = s_reg.lck[1] & ~s_reg.lck[2];
        s_next.fall  = ~s_reg.lck[1] & s_reg.lck[2];
        s_next.urise = s_reg.uck[1] & ~s_reg.uck[2];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg     <= '0;
            s_reg.rcf <= 2'h3;
            s_reg.stn <= 2'h3;
        end else begin
            s_reg <= s_next;
        end
    end

    // Data is taken from the same sample that first shows the clock high, i.e. at the rising edge
    assign pins.lck_rise     = s_reg.rise;
    assign pins.lck_fall     = s_reg.fall;
    assign pins.uck_rise     = s_reg.urise;
    assign pins.reconfig_n_s = s_reg.rcf[1];
    assign pins.status_n_s   = s_reg.stn[1];
    assign pins.data_s       = s_reg.d3;
endmodule : pin_sampler

// >>> verif/cfg_host_model.sv
// Behavioural configuration host driving the load port pins
`timescale 1ns/1ps
module cfg_host_model (
    output logic        load_clock,
    output logic        user_init_clock,
    output logic        reconfig_n,
    output logic [31:0] data_pins
);
    // Idle pins: load clock parked low, request inactive, init clock free running
    initial begin
        load_clock = 1'b0;
        reconfig_n = 1'b1;
        data_pins = 32'h0;
        user_init_clock = 1'b0;
        #2;
        forever #40 user_init_clock = ~user_init_clock;
    end

    // Request held low for the given time; pins move 3 ns after a clock edge, task ends on an edge
    task automatic request(input int low_ns);
        #3 reconfig_n = 1'b0;
        #(low_ns) reconfig_n = 1'b1;
        #7;
    endtask : request

    // One word held stable over r rising edges at 80 ns period
    task automatic word(input logic [31:0] d, input int r);
        #3 data_pins = d;
        repeat (r) begin
            #40 load_clock = 1'b1;
            #40 load_clock = 1'b0;
        end
        #7;
    endtask : word

    // Extra edges after completion, bus shows no stale word
    task automatic falls(input int n);
        word(~data_pins, n);
    endtask : falls
endmodule : cfg_host_model

// >>> verif/parallel_config_load_interface_tb_top.sv
// Self-checking bench for the parallel configuration load port
`timescale 1ns/1ps
module parallel_config_load_interface_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, data_pins, cfg_word, q;
    logic        load_clock, user_init_clock, reconfig_n, status_n_in, status_n_out, status_n_oe_n;
    logic        cfg_done, init_done_out, init_done_oe_n, user_mode, cfg_word_valid;
    logic [3:0]  x;
    time         t0;
    logic [31:0] got[$];
    int          n_fail = 0, compares = 0, k;

    // Wired status line with pull-up
    assign status_n_in = status_n_oe_n ? 1'b1 : status_n_out;

    parallel_config_load_interface #(.POR_CYC(20), .STATUS_CYC(30), .USR_INIT_EDGES(4)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .load_clock(load_clock), .user_init_clock(user_init_clock), .reconfig_n(reconfig_n),
        .data_pins(data_pins), .status_n_in(status_n_in), .status_n_out(status_n_out),
        .status_n_oe_n(status_n_oe_n), .cfg_done(cfg_done), .init_done_out(init_done_out),
        .init_done_oe_n(init_done_oe_n), .user_mode(user_mode), .cfg_word(cfg_word),
        .cfg_word_valid(cfg_word_valid));

    cfg_host_model hm (.load_clock(load_clock), .user_init_clock(user_init_clock),
        .reconfig_n(reconfig_n), .data_pins(data_pins));

    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Collect every accepted word
    always @(posedge pclk) begin
        if (cfg_word_valid === 1'b1) got.push_back(cfg_word);
    end

    // Hang guard
    initial begin
        #600000;
        n_fail++;
        stop_test();
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] w, input string m);
        compares++;
        if (g !== w) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, g, w);
        end
    endtask : chk

    // One APB transfer; read data and error taken at the completing edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Count clock edges until a signal is high, bounded
    task automatic until1(ref logic s, input int lim);
        k = 0;
        while (s !== 1'b1 && k < lim) begin
            @(posedge pclk);
            k++;
        end
    endtask : until1

    // Full reconfiguration: request, load n words at ratio r, initialise
    task automatic run(input logic [31:0] ctrl, input int r, input int n, input logic [31:0] msk);
        apb(1'b1, 12'h004, 32'(n));
        apb(1'b1, 12'h000, ctrl);
        got.delete();
        fork
            hm.request(2000);
            begin
                repeat (60) @(posedge pclk);
                chk(32'({status_n_oe_n, cfg_done}), 0, "request answer");
            end
        join
        until1(status_n_oe_n, 200);
        chk(32'(k >= 30 && k <= 40), 1, "status pulse");
        #2000;
        for (int i = 0; i < n; i++) begin
            chk(32'(cfg_done), 0, "done early");
            if (i < n - 1) hm.word(32'h9A5C3E17 + 32'(i) * 32'h01010101, r);
        end
        // Done and the init-done line are looked at while the last word's clocks still run
        fork
            hm.word(32'h9A5C3E17 + 32'(n - 1) * 32'h01010101, r);
            begin
                until1(cfg_done, 200);
                t0 = $time;
                chk(32'(cfg_done), 1, "done");
                if (ctrl[4]) chk(32'(init_done_oe_n | init_done_out), 0, "init low");
            end
        join
        apb(1'b0, 12'h00C, 32'h0);
        chk(q, 32'(n), "recv count");
        hm.falls(2);
        chk(32'(got.size()), 32'(n), "word count");
        for (int i = 0; i < n && i < got.size(); i++)
            chk(got[i], (32'h9A5C3E17 + 32'(i) * 32'h01010101) & msk, "word");
        until1(user_mode, 20000);
        if (!ctrl[5]) chk(32'(($time - t0) >= 175000 && ($time - t0) <= 437000), 1, "init time");
        @(posedge pclk);
        chk(32'({user_mode, cfg_done, status_n_oe_n, init_done_oe_n}), 32'hF, "user");
    endtask : run

    task automatic stop_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : stop_test

    // Main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(32'({cfg_done, status_n_oe_n}), 0, "por");
        until1(status_n_oe_n, 100);
        chk(32'(k >= 20 && k <= 26), 1, "por hold");
        apb(1'b0, 12'h000, 32'h0);
        chk(q, 32'h00000002, "ctrl reset");
        apb(1'b0, 12'h004, 32'h0);
        chk(q, 32'h00000100, "words reset");
        apb(1'b0, 12'h010, 32'h0);
        chk({q[30:0], e}, 32'h00000001, "unmapped");
        for (logic [4:0] c = 0; c < 12; c++) begin
            x = (c[3:2] == 0) ? (c[1] ? 4'h2 : 4'h1) : (c[3:2] == 1) ? (c[1] ? 4'h4 : c[0] ? 4'h2 : 4'h1)
                : (c[1] ? 4'h8 : c[0] ? 4'h4 : 4'h1);
            apb(1'b1, 12'h000, {28'h0, c[0], c[1], c[3:2]});
            apb(1'b0, 12'h008, 32'h0);
            chk({28'h0, q[15:12]}, {28'h0, x}, "ratio");
        end
        run(32'h00000001, 1, 3, 32'h0000FFFF);
        run(32'h00000014, 2, 2, 32'h000000FF);
        run(32'h00000036, 8, 2, 32'hFFFFFFFF);
        stop_test();
    end
endmodule : parallel_config_load_interface_tb_top
